// >>> design/deep_sleep_clock_gate_bank.sv
/*
 Deep-sleep clock gate bank: three gating registers, selection by power
 state, glitch-free per-unit enables, bus fault for gated units.
 Assumes one clock, synchronous inputs, a gate cell that latches its
 enable while the clock is low (enables change only after a rising edge).
*/
`timescale 1ns/10ps
`default_nettype none

// What this block does
// (R1) A set enable bit clocks its unit; a clear bit stops its clock.
// (R2) Access to a unit whose clock is off answers with a bus fault.
// (R3) Deep-sleep gating register resets to all zeros.
// (R4) Reserved bits are read-only and read as zero.
// (R5) Apply the run, sleep or deep-sleep register matching the power state.
// (R6) Sleep and deep-sleep registers apply only when auto gating select is set.
// (R7) Comparators 2,1,0 gated by bits 26,25,24, reset zero.
// (R8) Timers 3 to 0 gated by bits 19 to 16, reset zero.
// (R9) Two-wire 14,12; quadrature 8; sync serial 5,4; async serial 2,1,0.
// (R10) Deep-sleep gating register decoded at byte offset 0x124.
// (R11) Software must enable every unit it needs in deep-sleep.
// (R12) Enable changes never truncate or glitch a gated clock.
module deep_sleep_clock_gate_bank #(
    parameter int unsigned UNITS = ds_gate_pkg::NUM_UNITS
) (
    // System
    input wire logic clk,
    input wire logic rst_b,
    // Register port
    input wire ds_gate_pkg::reg_req_s reg_req,
    output logic [31:0] rdata,
    // Power state
    input wire ds_gate_pkg::power_state_e power_state,
    // Peripheral access check
    input wire ds_gate_pkg::unit_access_s unit_access,
    output logic bus_fault,
    // Clock enables to the gate cells
    output logic [31:0] unit_clk_en,
    // Interrupt
    output logic irq
);
    // Refused at elaboration: the enables map one to one onto register bits
    if (UNITS != ds_gate_pkg::NUM_UNITS) begin : g_units_check
        $error("UNITS must equal the gating register width");
    end

    logic [31:0] run_gate;
    logic [31:0] sleep_gate;
    logic [31:0] deep_gate;
    logic [31:0] run_cfg;
    logic [ds_gate_pkg::IRQ_W-1:0] irq_status;
    logic [ds_gate_pkg::IRQ_W-1:0] irq_mask;
    logic [4:0] fault_unit;
    logic [31:0] next_clk_en;
    logic [31:0] sel_gate;
    logic [31:0] next_rdata;
    logic wr;
    logic rd;
    logic fault_event;
    logic change_event;
    logic [ds_gate_pkg::IRQ_W-1:0] set_bits;

    assign wr = reg_req.wr;
    assign rd = reg_req.rd;

    // Software-owned gating registers; reserved bits never store
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            run_gate <= ds_gate_pkg::GATE_RESET;
            sleep_gate <= ds_gate_pkg::GATE_RESET;
            deep_gate <= ds_gate_pkg::GATE_RESET; // [R3] [R11]
            run_cfg <= ds_gate_pkg::RUN_CFG_RESET;
        end else if (wr) begin
            unique case (reg_req.addr)
                ds_gate_pkg::OFF_RUN_GATE: begin
                    run_gate <= reg_req.wdata & ds_gate_pkg::GATE_WR_MASK;
                end
                ds_gate_pkg::OFF_SLEEP_GATE: begin
                    sleep_gate <= reg_req.wdata & ds_gate_pkg::GATE_WR_MASK;
                end
                ds_gate_pkg::OFF_DEEP_GATE: begin // [R10]
                    deep_gate <= reg_req.wdata & ds_gate_pkg::GATE_WR_MASK; // [R4] [R7] [R8] [R9]
                end
                ds_gate_pkg::OFF_RUN_CFG: begin
                    run_cfg <= reg_req.wdata & ds_gate_pkg::RUN_CFG_MASK;
                end
                default: begin
                end
            endcase
        end
    end

    // Choose the register for the present power state
    always_comb begin
        sel_gate = run_gate;
        if (run_cfg[ds_gate_pkg::AUTO_GATE_BIT]) begin // [R6]
            unique case (power_state) // [R5]
                ds_gate_pkg::PWR_SLEEP: sel_gate = sleep_gate;
                ds_gate_pkg::PWR_DEEP: sel_gate = deep_gate;
                default: sel_gate = run_gate;
            endcase
        end
        next_clk_en = sel_gate & ds_gate_pkg::GATE_WR_MASK;
    end

    // Enables leave a flop right after the rising edge, so the low-phase
    // latch in each gate cell sees a stable level: no runt pulses
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            unit_clk_en <= ds_gate_pkg::GATE_RESET;
        end else begin
            unit_clk_en <= next_clk_en; // [R1] [R12]
        end
    end

    // Fault on access to an unclocked unit; registered, high one cycle per cycle that the access request is held
    assign fault_event = unit_access.req && !unit_clk_en[unit_access.unit];

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_fault <= 1'b0;
            fault_unit <= 5'h00;
        end else begin
            bus_fault <= fault_event; // [R2]
            if (fault_event) begin
                fault_unit <= unit_access.unit;
            end
        end
    end

    // Interrupt: sticky events, write one to clear, set beats clear
    assign change_event = next_clk_en != unit_clk_en;
    always_comb begin
        set_bits = '0;
        set_bits[ds_gate_pkg::IRQ_FAULT] = fault_event;
        set_bits[ds_gate_pkg::IRQ_STATE_CHANGE] = change_event;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_status <= '0;
            irq_mask <= '0;
        end else begin
            if (wr && reg_req.addr == ds_gate_pkg::OFF_IRQ_STATUS) begin
                irq_status <= (irq_status & ~reg_req.wdata[ds_gate_pkg::IRQ_W-1:0])
                    | set_bits;
            end else begin
                irq_status <= irq_status | set_bits;
            end
            if (wr && reg_req.addr == ds_gate_pkg::OFF_IRQ_MASK) begin
                irq_mask <= reg_req.wdata[ds_gate_pkg::IRQ_W-1:0];
            end
        end
    end

    assign irq = |(irq_status & irq_mask);

    // Read data one cycle after the strobe, zero otherwise
    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (reg_req.addr)
            ds_gate_pkg::OFF_RUN_GATE: next_rdata = run_gate;
            ds_gate_pkg::OFF_SLEEP_GATE: next_rdata = sleep_gate;
            ds_gate_pkg::OFF_DEEP_GATE: next_rdata = deep_gate; // [R4] [R10]
            ds_gate_pkg::OFF_RUN_CFG: next_rdata = run_cfg;
            ds_gate_pkg::OFF_IRQ_STATUS: next_rdata = {30'h0, irq_status};
            ds_gate_pkg::OFF_IRQ_MASK: next_rdata = {30'h0, irq_mask};
            ds_gate_pkg::OFF_FAULT_INFO: next_rdata = {27'h0, fault_unit};
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= 32'h0000_0000;
        end else if (rd) begin
            rdata <= next_rdata;
        end else begin
            rdata <= 32'h0000_0000;
        end
    end
endmodule

`default_nettype wire

// >>> design/ds_gate_pkg.sv
/*
 Shared constants and carriers for the deep-sleep clock gate bank.
 Assumes a single 100 MHz system clock domain.
*/
package ds_gate_pkg;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned NUM_UNITS = 32;

    // Register byte offsets
    localparam logic [11:0] OFF_RUN_CFG = 12'h060;
    localparam logic [11:0] OFF_RUN_GATE = 12'h104;
    localparam logic [11:0] OFF_SLEEP_GATE = 12'h114;
    localparam logic [11:0] OFF_DEEP_GATE = 12'h124;
    localparam logic [11:0] OFF_IRQ_STATUS = 12'h130;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h134;
    localparam logic [11:0] OFF_FAULT_INFO = 12'h138;

    // Writable enable bits of the gating layout
    localparam logic [31:0] GATE_WR_MASK = 32'h070F_5137;
    localparam logic [31:0] GATE_RESET = 32'h0000_0000;
    localparam int unsigned AUTO_GATE_BIT = 27;
    localparam logic [31:0] RUN_CFG_MASK = 32'h0800_0000;
    localparam logic [31:0] RUN_CFG_RESET = 32'h0000_0000;

    // Field positions of the enable bits
    localparam int unsigned COMPARATOR_A_GATE = 24;
    localparam int unsigned GP_COUNTER_A_GATE = 16;
    localparam int unsigned TWO_WIRE_A_GATE = 12;
    localparam int unsigned QUADRATURE_DECODER_GATE = 8;
    localparam int unsigned SYNC_SERIAL_A_GATE = 4;
    localparam int unsigned ASYNC_SERIAL_A_GATE = 0;

    // Interrupt status bits
    localparam int unsigned IRQ_W = 2;
    localparam int unsigned IRQ_FAULT = 0;
    localparam int unsigned IRQ_STATE_CHANGE = 1;

    typedef enum logic [2:0] {
        PWR_RUN = 3'h1,
        PWR_SLEEP = 3'h2,
        PWR_DEEP = 3'h4
    } power_state_e;

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

    typedef struct packed {
        logic req;
        logic [4:0] unit;
    } unit_access_s;
endpackage

// >>> tb/gate_bank_monitor.sv
/*
 Port assertions for the deep-sleep clock gate bank.
 Bound to every bank instance; one clock domain, reset active low.
*/
`timescale 1ns/10ps
`default_nettype none
module gate_bank_monitor (
    // System
    input wire logic clk,
    input wire logic rst_b,
    // Watched ports
    input wire ds_gate_pkg::reg_req_s reg_req,
    input wire logic [31:0] rdata,
    input wire ds_gate_pkg::power_state_e power_state,
    input wire ds_gate_pkg::unit_access_s unit_access,
    input wire logic bus_fault,
    input wire logic [31:0] unit_clk_en,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    rdata_idle_a: assert property (rdata != 32'h0 |-> $past(reg_req.rd))
        else $error("read data without a read");
    readback_a: assert property ($past(reg_req.wr, 3) && $past(reg_req.rd)
        && $past(reg_req.addr, 3) == 12'h124 && $past(reg_req.addr) == 12'h124
        |-> rdata == ($past(reg_req.wdata, 3) & 32'h070F_5137))
        else $error("gating register readback wrong");
    unmapped_a: assert property (reg_req.rd && reg_req.addr == 12'h200 |=> rdata == 32'h0)
        else $error("unmapped read not zero");
    fault_off_a: assert property (unit_access.req && !unit_clk_en[unit_access.unit]
        |=> bus_fault) else $error("no fault for gated unit");
    fault_on_a: assert property (unit_access.req && unit_clk_en[unit_access.unit]
        |=> !bus_fault) else $error("fault for clocked unit");
    fault_cause_a: assert property (bus_fault |-> $past(unit_access.req))
        else $error("fault without access");
    en_reserved_a: assert property ((unit_clk_en & ~32'h070F_5137) == 32'h0)
        else $error("enable on reserved position");
    stable_en_a: assert property (!reg_req.wr ##1 (!reg_req.wr && $stable(power_state))
        |=> $stable(unit_clk_en)) else $error("enable moved without cause");
    irq_rise_a: assert property ($rose(irq) |-> bus_fault || !$stable(unit_clk_en)
        || $past(reg_req.wr)) else $error("interrupt rose without cause");
    irq_hold_a: assert property ($fell(irq) |-> $past(reg_req.wr))
        else $error("interrupt fell without a write");
endmodule
bind deep_sleep_clock_gate_bank gate_bank_monitor i_gate_bank_monitor (.clk(clk),
    .rst_b(rst_b), .reg_req(reg_req), .rdata(rdata), .power_state(power_state),
    .unit_access(unit_access), .bus_fault(bus_fault), .unit_clk_en(unit_clk_en), .irq(irq));
`default_nettype wire

// >>> tb/deep_sleep_clock_gate_bank_tb_top.sv
/*
 Self-checking bench for the deep-sleep clock gate bank.
 Drives register port, power state and unit accesses directly.
*/
`timescale 1ns/10ps
`default_nettype none
module deep_sleep_clock_gate_bank_tb_top;
    logic clk;
    logic rst_b;
    ds_gate_pkg::reg_req_s reg_req;
    ds_gate_pkg::power_state_e power_state;
    ds_gate_pkg::unit_access_s unit_access;
    logic [31:0] rdata;
    logic [31:0] unit_clk_en;
    logic bus_fault;
    logic irq;
    int fails;
    int checks;
    deep_sleep_clock_gate_bank i_deep_sleep_clock_gate_bank (.clk(clk), .rst_b(rst_b),
        .reg_req(reg_req), .rdata(rdata), .power_state(power_state), .unit_access(unit_access),
        .bus_fault(bus_fault), .unit_clk_en(unit_clk_en), .irq(irq));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Trailing idle edge so the next strobe never lands in the same step
    task automatic wr(input logic [11:0] addr, input logic [31:0] data);
        reg_req.wr <= 1'b1;
        reg_req.addr <= addr;
        reg_req.wdata <= data;
        @(posedge clk);
        reg_req.wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [11:0] addr, input logic [31:0] exp);
        reg_req.rd <= 1'b1;
        reg_req.addr <= addr;
        @(posedge clk);
        reg_req.rd <= 1'b0;
        @(negedge clk);
        chk("rdata", exp, rdata);
        @(posedge clk);
    endtask
    task automatic acc(input logic [4:0] unit, input logic exp);
        unit_access <= '{req: 1'b1, unit: unit};
        @(posedge clk);
        unit_access.req <= 1'b0;
        @(negedge clk);
        chk("bus_fault", {31'h0, exp}, {31'h0, bus_fault});
        @(posedge clk);
    endtask
    // Settle margin covers register then enable stage
    task automatic en(input logic [31:0] exp);
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("unit_clk_en", exp, unit_clk_en);
        @(posedge clk);
    endtask
    task automatic irq_is(input logic exp);
        @(negedge clk);
        chk("irq", {31'h0, exp}, {31'h0, irq});
        @(posedge clk);
    endtask
    task automatic wrap_up();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #200000;
        fails++;
        wrap_up();
    end
    initial begin
        fails = 0;
        checks = 0;
        rst_b = 1'b0;
        reg_req = '0;
        power_state = ds_gate_pkg::PWR_RUN;
        unit_access = '0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd(12'h124, 32'h0);
        wr(12'h124, 32'hFFFF_FFFF);
        rd(12'h124, 32'h070F_5137);
        rd(12'h200, 32'h0);
        $display("register test done");
        wr(12'h124, 32'h0100_0011);
        wr(ds_gate_pkg::OFF_RUN_CFG, 32'h0800_0000);
        power_state <= ds_gate_pkg::PWR_DEEP;
        en(32'h0100_0011);
        acc(5'd24, 1'b0);
        acc(5'd16, 1'b1);
        power_state <= ds_gate_pkg::PWR_RUN;
        en(32'h0);
        wr(ds_gate_pkg::OFF_RUN_CFG, 32'h0);
        power_state <= ds_gate_pkg::PWR_DEEP;
        en(32'h0);
        acc(5'd0, 1'b1);
        wr(ds_gate_pkg::OFF_RUN_GATE, 32'h0000_1000);
        en(32'h0000_1000);
        wr(ds_gate_pkg::OFF_SLEEP_GATE, 32'hFFFF_FFFF);
        rd(ds_gate_pkg::OFF_SLEEP_GATE, 32'h070F_5137);
        wr(ds_gate_pkg::OFF_RUN_CFG, 32'h0800_0000);
        power_state <= ds_gate_pkg::PWR_SLEEP;
        en(32'h070F_5137);
        power_state <= ds_gate_pkg::PWR_RUN;
        en(32'h0000_1000);
        $display("selection test done");
        irq_is(1'b0);
        wr(ds_gate_pkg::OFF_IRQ_MASK, 32'h1);
        irq_is(1'b1);
        wr(ds_gate_pkg::OFF_IRQ_STATUS, 32'h1);
        irq_is(1'b0);
        acc(5'd8, 1'b1);
        irq_is(1'b1);
        rd(ds_gate_pkg::OFF_FAULT_INFO, 32'h0000_0008);
        rd(ds_gate_pkg::OFF_IRQ_STATUS, 32'h0000_0003);
        rd(ds_gate_pkg::OFF_IRQ_MASK, 32'h0000_0001);
        $display("interrupt test done");
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd(12'h124, 32'h0);
        en(32'h0);
        irq_is(1'b0);
        $display("reset test done");
        wrap_up();
    end
endmodule
`default_nettype wire
